// ==== sim/scf_client.sv ====
// upstream client model: fault reports, transactions, maintenance ops
// driven off the rising edge of clk_i; fields invert once released
`timescale 1ns/1ps
module scf_client (
  input wire clk_i,
  output reg [25:0] flt_o = 26'h0,
  output reg [6:0] txn_o = 7'h0,
  output reg [2:0] mnt_o = 3'h0
);
  task fault(input [24:0] f);
    begin
      @(posedge clk_i);
      flt_o <= {1'h1, f};
      @(posedge clk_i);
      flt_o <= {1'h0, ~f};
    end
  endtask
  task txn(input [5:0] a);
    begin
      @(posedge clk_i);
      txn_o <= {1'h1, a};
      @(posedge clk_i);
      txn_o <= {1'h0, ~a};
    end
  endtask
  task mnt(input [1:0] k);
    begin
      @(posedge clk_i);
      mnt_o <= {1'h1, k};
      @(posedge clk_i);
      mnt_o <= {1'h0, ~k};
    end
  endtask
endmodule

// ==== sim/scf_fault_ctrl_bench.sv ====
// testbench for the stage 2 bank fault and control block
// wishbone master here; client model drives fault, txn and maint inputs
`timescale 1ns/1ps
`include "scf_regs.vh"
module scf_fault_ctrl_bench;
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  reg [11:0] adr_i = 12'h0;
  reg [3:0] sel_i = 4'hF;
  reg [31:0] dat_i = 32'h0;
  wire [31:0] dat_o;
  wire [25:0] flt_o;
  wire [6:0] txn_o;
  wire [2:0] mnt_o;
  wire [7:0] fault_bank_i;
  wire [1:0] fault_kind_i, fault_level_i, fault_last_level_i, maint_kind_i, maint_kind_o;
  wire [1:0] txn_walloc_i, txn_ralloc_i, txn_share_i, txn_walloc_o, txn_ralloc_o, txn_share_o;
  wire ack_o, fault_valid_i, fault_async_i, fault_walk_i, fault_atop_i, fault_ns_attr_i;
  wire fault_ns_client_i, fault_instr_i, fault_priv_i, fault_write_i, fault_nest_walk_i;
  wire fault_walk_off_i, fault_out_of_range_i, txn_valid_i, maint_valid_i, txn_valid_o;
  wire txn_translate_o, maint_bcast_o, maint_local_o, translate_en_o, force_broadcast_o;
  integer bad_count = 0;
  integer n_compared = 0;
  assign {fault_valid_i, fault_bank_i, fault_async_i, fault_walk_i, fault_atop_i,
    fault_ns_attr_i, fault_ns_client_i, fault_instr_i, fault_priv_i, fault_write_i,
    fault_nest_walk_i, fault_kind_i, fault_level_i, fault_last_level_i, fault_walk_off_i,
    fault_out_of_range_i} = flt_o;
  assign {txn_valid_i, txn_walloc_i, txn_ralloc_i, txn_share_i} = txn_o;
  assign {maint_valid_i, maint_kind_i} = mnt_o;
  scf_fault_ctrl scf_fault_ctrl_i (.*);
  scf_client scf_client_i (.*);
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one classic cycle; a read is compared against exp
  task bus(input w, input [11:0] a, input [31:0] d, input [31:0] exp);
    begin
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
      @(posedge clk_i);
      while (ack_o !== 1'h1) @(posedge clk_i);
      if (!w) check(dat_o, exp);
      {cyc_i, stb_i} <= 2'h0;
    end
  endtask
  task fcase(input [7:0] b, input [8:0] fl, input [1:0] k, input [5:0] lv, input [1:0] e);
    begin
      scf_client_i.fault({b, fl, k, lv});
      bus(1'h0, `SCF_OFS_SYN_MAIN, 32'h0, {8'h0, b, 4'h0, fl, 1'h0, e});
      bus(1'h0, `SCF_OFS_SYN_EXTRA, 32'h0, {24'h0, b});
    end
  endtask
  task tchk(input [5:0] a, input t, input [5:0] e);
    begin
      scf_client_i.txn(a);
      #1;
      check({24'h0, txn_valid_o, txn_translate_o, txn_walloc_o, txn_ralloc_o, txn_share_o},
        {24'h0, 1'h1, t, e});
    end
  endtask
  task t_regs;
    begin
      bus(1'h0, `SCF_OFS_CTRL, 32'h0, `SCF_CTL_RESET);
      bus(1'h0, `SCF_OFS_SYN_MAIN, 32'h0, `SCF_SYN_RESET);
      bus(1'h0, `SCF_OFS_PMU_AUTH, 32'h0, 32'h0);
      bus(1'h1, `SCF_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
      bus(1'h0, `SCF_OFS_CTRL, 32'h0, 32'h0FE00001);
      bus(1'h1, `SCF_OFS_PMU_AUTH, 32'hFFFFFFFF, 32'h0);
      bus(1'h0, `SCF_OFS_PMU_AUTH, 32'h0, 32'h0);
      bus(1'h1, `SCF_OFS_SYN_MAIN, 32'hFFFFFFFF, 32'h0);
      bus(1'h0, `SCF_OFS_SYN_MAIN, 32'h0, 32'h00FF0FFB);
      bus(1'h1, `SCF_OFS_SYN_EXTRA, 32'hA5A55A5A, 32'h0);
      bus(1'h0, `SCF_OFS_SYN_EXTRA, 32'h0, 32'hA5A55A5A);
      sel_i <= 4'h3;
      bus(1'h1, `SCF_OFS_SYN_EXTRA, 32'h12345678, 32'h0);
      sel_i <= 4'hF;
      bus(1'h0, `SCF_OFS_SYN_EXTRA, 32'h0, 32'hA5A55678);
      bus(1'h0, 12'h100, 32'h0, 32'h0);
      bus(1'h1, `SCF_OFS_CTRL, 32'h0, 32'h0);
      $display("regs test done");
    end
  endtask
  task t_fault;
    begin
      fcase(8'h5A, 9'h155, `SCF_KIND_TRANSL, 6'h3A, 2'h1);
      fcase(8'hC3, 9'h0AA, `SCF_KIND_ACCESS, 6'h2C, 2'h2);
      fcase(8'h01, 9'h1FF, `SCF_KIND_PERM, 6'h1C, 2'h3);
      fcase(8'h80, 9'h000, `SCF_KIND_WALK, 6'h34, 2'h3);
      fcase(8'h3C, 9'h0F0, `SCF_KIND_TRANSL, 6'h21, 2'h1);
      fcase(8'hFF, 9'h00F, `SCF_KIND_TRANSL, 6'h20, 2'h2);
      $display("fault test done");
    end
  endtask
  task t_attr;
    begin
      bus(1'h1, `SCF_OFS_CTRL, 32'h0B400000, 32'h0);
      tchk(6'h0A, 1'h0, 6'h2D);
      bus(1'h1, `SCF_OFS_CTRL, 32'h04C00000, 32'h0);
      tchk(6'h35, 1'h0, 6'h31);
      bus(1'h1, `SCF_OFS_CTRL, 32'h08000000, 32'h0);
      tchk(6'h1B, 1'h0, 6'h23);
      bus(1'h1, `SCF_OFS_CTRL, 32'h01800000, 32'h0);
      tchk(6'h2C, 1'h0, 6'h0E);
      bus(1'h1, `SCF_OFS_CTRL, 32'h0B400001, 32'h0);
      tchk(6'h24, 1'h1, 6'h24);
      check({31'h0, translate_en_o}, 32'h1);
      $display("attribute test done");
    end
  endtask
  task t_bcast;
    begin
      bus(1'h1, `SCF_OFS_CTRL, 32'h00200000, 32'h0);
      scf_client_i.mnt(2'h2);
      #1;
      check({28'h0, maint_bcast_o, maint_local_o, maint_kind_o}, 32'hA);
      check({31'h0, force_broadcast_o}, 32'h1);
      bus(1'h1, `SCF_OFS_CTRL, 32'h0, 32'h0);
      scf_client_i.mnt(2'h1);
      #1;
      check({28'h0, maint_bcast_o, maint_local_o, maint_kind_o}, 32'h5);
      $display("broadcast test done");
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #20000;
    bad_count = bad_count + 1;
    results;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs;
    t_fault;
    t_attr;
    t_bcast;
    results;
  end
endmodule

// ==== sim/scf_fault_ctrl_monitor.sv ====
// checker for the stage 2 bank fault and control block
// sees only the top module ports; one clock domain
`timescale 1ns/1ps
module scf_fault_ctrl_chk (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire txn_valid_i,
  input wire [1:0] txn_walloc_i,
  input wire [1:0] txn_ralloc_i,
  input wire [1:0] txn_share_i,
  input wire txn_valid_o,
  input wire txn_translate_o,
  input wire [1:0] txn_walloc_o,
  input wire [1:0] txn_ralloc_o,
  input wire [1:0] txn_share_o,
  input wire maint_valid_i,
  input wire [1:0] maint_kind_i,
  input wire maint_bcast_o,
  input wire maint_local_o,
  input wire [1:0] maint_kind_o,
  input wire translate_en_o,
  input wire force_broadcast_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********
  // calm: reset was low at the previous edge
  // ********
  reg calm = 1'h0;
  always @(posedge clk_i) begin
    calm <= !rst_i;
  end
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_ack_on_request: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_txn_valid_lag: assert property (calm |-> txn_valid_o == $past(txn_valid_i))
    else $error("txn valid lag");
  a_pass_enabled: assert property (calm && txn_valid_o && txn_translate_o
    |-> {txn_walloc_o, txn_ralloc_o, txn_share_o}
    == $past({txn_walloc_i, txn_ralloc_i, txn_share_i}))
    else $error("enabled bank altered attributes");
  a_bcast_forced: assert property (calm && $past(maint_valid_i) && force_broadcast_o
    |-> maint_bcast_o && !maint_local_o)
    else $error("no broadcast");
  a_local_plain: assert property (calm && $past(maint_valid_i) && !force_broadcast_o
    |-> !maint_bcast_o && maint_local_o)
    else $error("no local op");
  a_maint_idle: assert property (calm && !$past(maint_valid_i)
    |-> !maint_bcast_o && !maint_local_o)
    else $error("maint pulse without request");
  a_maint_kind: assert property (calm && $past(maint_valid_i)
    |-> maint_kind_o == $past(maint_kind_i))
    else $error("maint kind lost");
  c_enabled_txn: cover property (txn_valid_o && txn_translate_o);
  c_bcast: cover property (maint_bcast_o);
  c_local: cover property (maint_local_o);
  c_disabled_txn: cover property (txn_valid_o && !translate_en_o);
endmodule
bind scf_fault_ctrl scf_fault_ctrl_chk scf_chk_i (.*);

// ==== verilog/scf_fault_ctrl.v ====
// stage 2 context bank: fault syndrome capture, bank system control register,
// attribute override for disabled translation and maintenance broadcast steering
// assumes fault and transaction inputs come from logic on clk_i; wishbone classic slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "scf_regs.vh"

// Notes on behaviour
// - nested translation records the stage 1 bank index in bits 23:16
// - without nested support the main syndrome bank index reads zero and ignores writes; the second syndrome register still records it
// - async flag is 1 for asynchronously recorded faults, else 0
// - walk fault flag is 1 when fault arose in a table walk
// - translation operation flag is 1 when fault arose in such operation
// - record non-secure attribute and non-secure client bits, secure gives 0
// - record instruction, privileged and write attributes of the faulting access
// - nested walk flag set for stage 2 fault of stage 1 walk; zero without nesting
// - fault level coded 01, 10, 11 for levels 1 to 3
// - walk faults report the level of the walk in progress
// - translation faults report table level; disabled walk or out of range gives 1
// - access faults give table level; permission faults give last level used
// - two 32-bit read-write syndrome registers; second layout is our own
// - disabled bank takes write allocate hint from the control field unless that field holds 01, which passes the incoming hint
// - disabled bank takes read allocate hint from the control field unless that field holds 01, which passes the incoming hint
// - disabled bank merges shareability from the control field with the incoming value
// - shareability combines with the preceding stage, keeping the wider domain
// - force broadcast bit makes maintenance operations broadcast
// - control register is 32-bit read-write with top four bits reserved
// - read-only performance monitor authentication status at its offset
// - control bit 0 enables translation; clear means override fields govern
module scf_fault_ctrl #(
  parameter NESTED = 1,
  parameter [31:0] PMU_AUTH_VALUE = 32'h0000_0000
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // fault report from the translation logic
  input wire fault_valid_i,
  input wire [7:0] fault_bank_i,
  input wire fault_async_i,
  input wire fault_walk_i,
  input wire fault_atop_i,
  input wire fault_ns_attr_i,
  input wire fault_ns_client_i,
  input wire fault_instr_i,
  input wire fault_priv_i,
  input wire fault_write_i,
  input wire fault_nest_walk_i,
  input wire [1:0] fault_kind_i,
  input wire [1:0] fault_level_i,
  input wire [1:0] fault_last_level_i,
  input wire fault_walk_off_i,
  input wire fault_out_of_range_i,
  // transaction attributes from the preceding step
  input wire txn_valid_i,
  input wire [1:0] txn_walloc_i,
  input wire [1:0] txn_ralloc_i,
  input wire [1:0] txn_share_i,
  output reg txn_valid_o,
  output reg txn_translate_o,
  output reg [1:0] txn_walloc_o,
  output reg [1:0] txn_ralloc_o,
  output reg [1:0] txn_share_o,
  // maintenance operations
  input wire maint_valid_i,
  input wire [1:0] maint_kind_i,
  output reg maint_bcast_o,
  output reg maint_local_o,
  output reg [1:0] maint_kind_o,
  // live control state
  output reg translate_en_o,
  output reg force_broadcast_o
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [31:0] syn_main;
  reg [31:0] syn_extra;
  reg [31:0] ctrl;
  reg [31:0] next_syn_main;
  reg [31:0] next_syn_extra;
  reg [31:0] next_ctrl;
  reg [31:0] rd_data;
  reg [31:0] fault_word;
  reg [31:0] wmask;
  reg [1:0] fault_lvl;
  reg [1:0] share_mix;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire bus_req = cyc_i & stb_i;
  wire bus_wr = bus_req & we_i & ack_o;
  wire [11:0] word_adr = {adr_i[11:2], 2'h0};
  wire hit_ctrl = (word_adr == `SCF_OFS_CTRL);
  wire hit_main = (word_adr == `SCF_OFS_SYN_MAIN);
  wire hit_extra = (word_adr == `SCF_OFS_SYN_EXTRA);
  wire [1:0] walloc_pick;
  wire [1:0] ralloc_pick;

  // only fields that exist in this bank are writable
  localparam [31:0] CTRL_MASK = (32'h1 << `SCF_CTL_WALLOC_HI)
    | (32'h1 << `SCF_CTL_WALLOC_LO)
    | (32'h1 << `SCF_CTL_RALLOC_HI)
    | (32'h1 << `SCF_CTL_RALLOC_LO)
    | (32'h1 << `SCF_CTL_SHARE_HI)
    | (32'h1 << `SCF_CTL_SHARE_LO)
    | (32'h1 << `SCF_CTL_FBCAST)
    | (32'h1 << `SCF_CTL_ENABLE);
  localparam [31:0] BANK_MASK = (32'h1 << (`SCF_SYN_BANK_HI + 1))
    - (32'h1 << `SCF_SYN_BANK_LO);
  localparam [31:0] SYN_MASK_BASE = (32'h1 << `SCF_SYN_ASYNC)
    | (32'h1 << `SCF_SYN_WALK)
    | (32'h1 << `SCF_SYN_ATOP)
    | (32'h1 << `SCF_SYN_NS_ATTR)
    | (32'h1 << `SCF_SYN_NS_CLIENT)
    | (32'h1 << `SCF_SYN_INSTR)
    | (32'h1 << `SCF_SYN_PRIV)
    | (32'h1 << `SCF_SYN_WRITE)
    | (32'h1 << `SCF_SYN_LVL_HI)
    | (32'h1 << `SCF_SYN_LVL_LO);
  localparam [31:0] NEST_MASK = BANK_MASK | (32'h1 << `SCF_SYN_NEST_WALK);
  localparam [31:0] SYN_MASK = (NESTED != 0) ? (SYN_MASK_BASE | NEST_MASK) : SYN_MASK_BASE;

  // ****************************************************************
  // fault level selection
  // ****************************************************************
  always @* begin
    case (fault_kind_i)
      `SCF_KIND_WALK: begin
        fault_lvl = fault_level_i;
      end
      `SCF_KIND_TRANSL: begin
        if (fault_walk_off_i | fault_out_of_range_i) begin
          fault_lvl = `SCF_LVL_1;
        end else begin
          fault_lvl = fault_level_i;
        end
      end
      `SCF_KIND_ACCESS: begin
        fault_lvl = fault_level_i;
      end
      `SCF_KIND_PERM: begin
        fault_lvl = fault_last_level_i;
      end
      default: begin
        fault_lvl = fault_level_i;
      end
    endcase
  end

  // ****************************************************************
  // syndrome word assembly
  // ****************************************************************
  always @* begin
    fault_word = 32'h0000_0000;
    if (NESTED != 0) begin
      fault_word[`SCF_SYN_BANK_HI:`SCF_SYN_BANK_LO] = fault_bank_i;
      fault_word[`SCF_SYN_NEST_WALK] = fault_nest_walk_i;
    end
    fault_word[`SCF_SYN_ASYNC] = fault_async_i;
    fault_word[`SCF_SYN_WALK] = fault_walk_i;
    fault_word[`SCF_SYN_ATOP] = fault_atop_i;
    fault_word[`SCF_SYN_NS_ATTR] = fault_ns_attr_i;
    fault_word[`SCF_SYN_NS_CLIENT] = fault_ns_client_i;
    fault_word[`SCF_SYN_INSTR] = fault_instr_i;
    fault_word[`SCF_SYN_PRIV] = fault_priv_i;
    fault_word[`SCF_SYN_WRITE] = fault_write_i;
    fault_word[`SCF_SYN_LVL_HI:`SCF_SYN_LVL_LO] = fault_lvl;
  end

  // ****************************************************************
  // control register write
  // ****************************************************************
  always @* begin
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  // a write lands at the edge where the master samples ack high
  always @* begin
    next_ctrl = ctrl;
    if (bus_wr & hit_ctrl) begin
      // reserved bits stay zero whatever software writes
      next_ctrl = (ctrl & ~(wmask & CTRL_MASK)) | (dat_i & wmask & CTRL_MASK);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `SCF_CTL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ****************************************************************
  // syndrome write and fault capture
  // ****************************************************************
  always @* begin
    next_syn_main = syn_main;
    next_syn_extra = syn_extra;
    if (bus_wr & hit_main) begin
      next_syn_main = (syn_main & ~(wmask & SYN_MASK)) | (dat_i & wmask & SYN_MASK);
    end
    if (bus_wr & hit_extra) begin
      next_syn_extra = (syn_extra & ~wmask) | (dat_i & wmask);
    end
    // a fault in the same cycle as a software write wins
    if (fault_valid_i) begin
      next_syn_main = fault_word;
      next_syn_extra = {24'h00_0000, fault_bank_i};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      syn_main <= `SCF_SYN_RESET;
      syn_extra <= `SCF_SYN_RESET;
    end else begin
      syn_main <= next_syn_main;
      syn_extra <= next_syn_extra;
    end
  end

  // ****************************************************************
  // wishbone read and acknowledge
  // ****************************************************************
  always @* begin
    case (word_adr)
      `SCF_OFS_CTRL: begin
        rd_data = ctrl;
      end
      `SCF_OFS_SYN_MAIN: begin
        rd_data = syn_main;
      end
      `SCF_OFS_SYN_EXTRA: begin
        rd_data = syn_extra;
      end
      `SCF_OFS_PMU_AUTH: begin
        rd_data = PMU_AUTH_VALUE;
      end
      default: begin
        // unmapped offsets read as zero
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req & ~ack_o;
      if (bus_req & ~ack_o) begin
        dat_o <= rd_data;
      end
    end
  end

  // ****************************************************************
  // attribute path for transactions
  // ****************************************************************
  // wider domain wins: outer (01) over inner (10) over none (11)
  always @* begin
    if (ctrl[`SCF_CTL_SHARE_HI:`SCF_CTL_SHARE_LO] == `SCF_SHARE_RSVD) begin
      share_mix = txn_share_i;
    end else if (txn_share_i == `SCF_SHARE_RSVD) begin
      share_mix = ctrl[`SCF_CTL_SHARE_HI:`SCF_CTL_SHARE_LO];
    end else if (txn_share_i < ctrl[`SCF_CTL_SHARE_HI:`SCF_CTL_SHARE_LO]) begin
      share_mix = txn_share_i;
    end else begin
      share_mix = ctrl[`SCF_CTL_SHARE_HI:`SCF_CTL_SHARE_LO];
    end
  end

  // ****************************************************************
  // allocate hint selection for a disabled bank
  // ****************************************************************
  scf_alloc_pick scf_alloc_pick_wr (
    .cfg_i(ctrl[`SCF_CTL_WALLOC_HI:`SCF_CTL_WALLOC_LO]),
    .hint_i(txn_walloc_i),
    .pick_o(walloc_pick)
  );

  scf_alloc_pick scf_alloc_pick_rd (
    .cfg_i(ctrl[`SCF_CTL_RALLOC_HI:`SCF_CTL_RALLOC_LO]),
    .hint_i(txn_ralloc_i),
    .pick_o(ralloc_pick)
  );

  // ****************************************************************
  // attribute pipeline
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      txn_valid_o <= 1'b0;
      txn_translate_o <= 1'b0;
      txn_walloc_o <= `SCF_ALLOC_DEFAULT;
      txn_ralloc_o <= `SCF_ALLOC_DEFAULT;
      txn_share_o <= `SCF_SHARE_RSVD;
    end else begin
      txn_valid_o <= txn_valid_i;
      txn_translate_o <= ctrl[`SCF_CTL_ENABLE];
      if (ctrl[`SCF_CTL_ENABLE]) begin
        txn_walloc_o <= txn_walloc_i;
        txn_ralloc_o <= txn_ralloc_i;
        txn_share_o <= txn_share_i;
      end else begin
        txn_walloc_o <= walloc_pick;
        txn_ralloc_o <= ralloc_pick;
        txn_share_o <= share_mix;
      end
    end
  end

  // ****************************************************************
  // maintenance steering and operation kind output
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      maint_bcast_o <= 1'b0;
      maint_local_o <= 1'b0;
      maint_kind_o <= 2'h0;
    end else begin
      maint_bcast_o <= maint_valid_i & ctrl[`SCF_CTL_FBCAST];
      maint_local_o <= maint_valid_i & ~ctrl[`SCF_CTL_FBCAST];
      maint_kind_o <= maint_kind_i;
    end
  end

  // ****************************************************************
  // live control outputs
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      translate_en_o <= 1'b0;
      force_broadcast_o <= 1'b0;
    end else begin
      translate_en_o <= ctrl[`SCF_CTL_ENABLE];
      force_broadcast_o <= ctrl[`SCF_CTL_FBCAST];
    end
  end

endmodule

// ****************************************************************
// allocate hint override for a disabled bank
// ****************************************************************
module scf_alloc_pick #(
  parameter W = 2
) (
  input wire [W-1:0] cfg_i,
  input wire [W-1:0] hint_i,
  output reg [W-1:0] pick_o
);

  localparam [W-1:0] RSVD = `SCF_ALLOC_RSVD;

  // the reserved code has no meaning of its own, so the incoming hint stands
  always @* begin
    if (cfg_i == RSVD) begin
      pick_o = hint_i;
    end else begin
      pick_o = cfg_i;
    end
  end

endmodule

// ==== verilog/scf_regs.vh ====
// register map and field layout of the stage 2 bank control and fault syndrome block
// assumes a 32-bit wishbone data path with byte addressing
`ifndef SCF_REGS_VH
`define SCF_REGS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SCF_OFS_CTRL 12'h000
`define SCF_OFS_SYN_MAIN 12'h068
`define SCF_OFS_SYN_EXTRA 12'h06C
`define SCF_OFS_PMU_AUTH 12'hFB8

// ****************************************************************
// syndrome main fields
// ****************************************************************
`define SCF_SYN_BANK_HI 23
`define SCF_SYN_BANK_LO 16
`define SCF_SYN_ASYNC 11
`define SCF_SYN_WALK 10
`define SCF_SYN_ATOP 9
`define SCF_SYN_NS_ATTR 8
`define SCF_SYN_NS_CLIENT 7
`define SCF_SYN_INSTR 6
`define SCF_SYN_PRIV 5
`define SCF_SYN_WRITE 4
`define SCF_SYN_NEST_WALK 3
`define SCF_SYN_LVL_HI 1
`define SCF_SYN_LVL_LO 0

// ****************************************************************
// control register fields
// ****************************************************************
`define SCF_CTL_WALLOC_HI 27
`define SCF_CTL_WALLOC_LO 26
`define SCF_CTL_RALLOC_HI 25
`define SCF_CTL_RALLOC_LO 24
`define SCF_CTL_SHARE_HI 23
`define SCF_CTL_SHARE_LO 22
`define SCF_CTL_FBCAST 21
`define SCF_CTL_ENABLE 0
`define SCF_CTL_RESET 32'h0000_0000
`define SCF_SYN_RESET 32'h0000_0000

// ****************************************************************
// encodings
// ****************************************************************
`define SCF_LVL_1 2'h1
`define SCF_SHARE_RSVD 2'h0
`define SCF_ALLOC_RSVD 2'h1
`define SCF_ALLOC_DEFAULT 2'h0
`define SCF_KIND_TRANSL 2'h0
`define SCF_KIND_ACCESS 2'h1
`define SCF_KIND_PERM 2'h2
`define SCF_KIND_WALK 2'h3

`endif
